// ### logic/cxe_pkg.sv
// Purpose: shared constants and types for the instruction execution unit
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   opcode codes run in declaration order; code zero is the no-op
package cxe_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_OPA   = 8'h04;
  localparam logic [7:0] REG_OPB   = 8'h08;
  localparam logic [7:0] REG_OPX   = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_RESLO = 8'h14;
  localparam logic [7:0] REG_RESHI = 8'h18;
  localparam logic [7:0] REG_INFO  = 8'h1C;

  // cycle counts per instruction class
  localparam logic [4:0] CYC_ONE   = 5'h01;
  localparam logic [4:0] CYC_TWO   = 5'h02;
  localparam logic [4:0] CYC_THREE = 5'h03;
  localparam logic [4:0] CYC_DIV   = 5'h12;

  // operand and storage figures
  localparam logic [15:0] ZERO16  = 16'h0000;
  localparam logic [3:0]  STK_D   = 4'h8;
  localparam logic [3:0]  DAW_LIM = 4'h9;
  localparam logic [8:0]  DAW_LO  = 9'h006;
  localparam logic [8:0]  DAW_HI  = 9'h060;

  // instruction word fields
  localparam int OPC_HI  = 23;
  localparam int OPC_LO  = 16;
  localparam int SEL_REG = 15;
  localparam int SEL_ZF  = 4;
  localparam int DBL_BIT = 24;
  localparam int ALT_BIT = 10;

  typedef enum logic [7:0] {
    op_nop, op_bit_test_skip_set, op_bit_test_to_flag,
    op_bit_test_then_set, op_compare_to_zero, op_compare_with_borrow,
    op_compare_skip_equal, op_compare_skip_greater, op_compare_skip_less,
    op_compare_skip_unequal, op_return_with_literal,
    op_decimal_adjust_byte, op_interrupt_hold_off, op_divide,
    op_find_first_one_msb, op_find_first_one_lsb, op_move_double,
    op_product_op, op_push, op_push_double, op_pop, op_pop_double,
    op_push_shadow, op_pop_shadow, op_power_save_entry, op_repeat,
    op_rotate_left_via_carry, op_rotate_right_via_carry, op_rotate_left,
    op_rotate_right, op_sign_extend, op_clear_upper_extend,
    op_table_read_high, op_table_read_low, op_table_write_high,
    op_table_write_low, op_shift_one, op_shift_multi, op_move_indirect,
    op_move_byte_literal, op_move_word_literal, op_negate
  } cxe_op_t;

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } cxe_flags_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cxe_wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic [23:0]       instr;
    logic              dbl;
    logic [15:0]       opa;
    logic [15:0]       opb;
    logic [15:0]       opx;
    cxe_flags_t        fl;
    cxe_flags_t        shadow;
    logic              watchdog_timeout_flag;
    logic              sleep;
    logic              sleep_md;
    logic              idle_md;
    logic [15:0]       res_lo;
    logic [15:0]       res_hi;
    logic [4:0]        cnt;
    logic [4:0]        cyc_last;
    logic              skip;
    logic [13:0]       hold;
    logic              hold_on;
    logic [15:0]       rep;
    logic [3:0]        sp;
    logic [7:0][15:0]  stk;
    logic [7:0][23:0]  mem;
  } cxe_state_t;

endpackage

// ### logic/cxe_exec_unit.sv
// Purpose: executes one subset of a 16-bit core instruction set
// Assumes: operands staged in registers, instruction written to command
// Notes:   all state in one struct; one comb copy, one clocked register
`timescale 1ns/1ps
`default_nettype none
module cxe_exec_unit (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // wishbone slave
  input  wire cxe_pkg::cxe_wb_req_t wb_req,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // core state
  output logic                      int_hold_off,
  output logic                      sleep_mode,
  output logic                      idle_mode
);

  cxe_pkg::cxe_state_t s_ff;
  cxe_pkg::cxe_state_t nxt_s;
  cxe_pkg::cxe_op_t    op;
  logic               acc;
  logic               wr;
  logic               go;
  logic [31:0]        wv;
  logic [23:0]        ins;
  logic [15:0]        a;
  logic [15:0]        b;
  logic [15:0]        bb;
  logic [15:0]        ea;
  logic [3:0]         bsel;
  logic [2:0]         ix;
  logic               skp;
  logic [4:0]         cyc;
  logic [31:0]        dvd;
  logic [31:0]        dvs;
  logic [31:0]        q32;
  logic [31:0]        r32;
  logic signed [33:0] pw;
  logic [8:0]         t;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // a - b - not(cin); z is sticky through zin
  function automatic cxe_pkg::cxe_flags_t sub_fl(input logic [15:0] x,
                                                 input logic [15:0] y,
                                                 input logic        cin,
                                                 input logic        zin);
    logic [16:0]         s;
    logic [4:0]          l;
    cxe_pkg::cxe_flags_t f;
    s    = {1'b0, x} + {1'b0, ~y} + {16'h0000, cin};
    l    = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
    f.c  = s[16];
    f.dc = l[4];
    f.n  = s[15];
    f.ov = (x[15] != y[15]) && (s[15] != x[15]);
    f.z  = zin & (s[15:0] == 16'h0000);
    return f;
  endfunction

  function automatic logic [15:0] sub_r(input logic [15:0] x,
                                        input logic [15:0] y,
                                        input logic        cin);
    return x + ~y + {15'h0000, cin};
  endfunction

  // position counts from 1 at the chosen end, 0 when none set
  function automatic logic [4:0] ff1(input logic [15:0] v,
                                     input logic        left);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (left ? v[15 - i] : v[i]) begin
        p = 5'(i + 1);
      end
    end
    return p;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    acc   = wb_req.cyc & wb_req.stb & s_ff.ack;
    wr    = acc & wb_req.we;
    wv    = wmerge(32'h0000_0000, wb_req.dat, wb_req.sel);
    // ack one cycle after request, dropped the cycle after
    nxt_s.ack = wb_req.cyc & wb_req.stb & ~s_ff.ack;
    if (nxt_s.ack) begin
      unique case (wb_req.adr)
        cxe_pkg::REG_CMD:   nxt_s.rdat = {7'h00, s_ff.dbl, s_ff.instr};
        cxe_pkg::REG_OPA:   nxt_s.rdat = {16'h0000, s_ff.opa};
        cxe_pkg::REG_OPB:   nxt_s.rdat = {16'h0000, s_ff.opb};
        cxe_pkg::REG_OPX:   nxt_s.rdat = {16'h0000, s_ff.opx};
        cxe_pkg::REG_STAT:  nxt_s.rdat = {20'h0_0000, s_ff.hold_on,
                                          s_ff.skip, s_ff.cnt != 5'h00,
                                          s_ff.idle_md, s_ff.sleep_md,
                                          s_ff.sleep, s_ff.watchdog_timeout_flag, s_ff.fl};
        cxe_pkg::REG_RESLO: nxt_s.rdat = {16'h0000, s_ff.res_lo};
        cxe_pkg::REG_RESHI: nxt_s.rdat = {16'h0000, s_ff.res_hi};
        cxe_pkg::REG_INFO:  nxt_s.rdat = {2'h0, s_ff.hold, 11'h000,
                                          s_ff.cyc_last};
        default:            nxt_s.rdat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (wb_req.adr)
        cxe_pkg::REG_OPA: nxt_s.opa = 16'(wmerge({16'h0000, s_ff.opa},
                                             wb_req.dat, wb_req.sel));
        cxe_pkg::REG_OPB: nxt_s.opb = 16'(wmerge({16'h0000, s_ff.opb},
                                             wb_req.dat, wb_req.sel));
        cxe_pkg::REG_OPX: nxt_s.opx = 16'(wmerge({16'h0000, s_ff.opx},
                                             wb_req.dat, wb_req.sel));
        cxe_pkg::REG_STAT: begin
          nxt_s.fl       = wv[4:0];
          nxt_s.watchdog_timeout_flag     = wv[5];
          nxt_s.sleep    = wv[6];
          nxt_s.sleep_md = wv[7];
          nxt_s.idle_md  = wv[8];
        end
        default: begin
        end
      endcase
    end
    // countdown of interrupt hold-off, one per instruction cycle
    nxt_s.hold = (s_ff.hold != 14'h0000) ? s_ff.hold - 14'h0001 : 14'h0000;
    // command refused while a previous one still runs
    go  = (wr && wb_req.adr == cxe_pkg::REG_CMD && s_ff.cnt == 5'h00)
          || (s_ff.cnt == 5'h01 && s_ff.rep != 16'h0000
              // repeat itself never relaunches, else it reloads forever
              && s_ff.instr[cxe_pkg::OPC_HI:cxe_pkg::OPC_LO]
                 != 8'(cxe_pkg::op_repeat));
    ins = (s_ff.cnt == 5'h00) ? wb_req.dat[23:0] : s_ff.instr;
    op   = cxe_pkg::cxe_op_t'(ins[cxe_pkg::OPC_HI:cxe_pkg::OPC_LO]);
    a    = s_ff.opa;
    b    = s_ff.opb;
    bsel = ins[cxe_pkg::SEL_REG] ? b[3:0] : ins[3:0];
    bb   = ins[cxe_pkg::SEL_REG] ? {11'h000, ins[4:0]} : b;
    ix   = a[2:0];
    ea   = a + {{6{ins[9]}}, ins[9:0]};
    skp  = 1'b0;
    cyc  = cxe_pkg::CYC_ONE;
    dvd  = 32'h0000_0000;
    dvs  = 32'h0000_0000;
    q32  = 32'h0000_0000;
    r32  = 32'h0000_0000;
    pw   = 34'sh0_0000_0000;
    t    = 9'h000;
    if (go) begin
      if (s_ff.cnt == 5'h00) begin
        nxt_s.instr = ins;
        nxt_s.dbl   = wb_req.dat[cxe_pkg::DBL_BIT];
      end else begin
        nxt_s.rep = s_ff.rep - 16'h0001;
      end
      unique case (op)
        cxe_pkg::op_bit_test_skip_set: skp = a[bsel];
        cxe_pkg::op_bit_test_to_flag, cxe_pkg::op_bit_test_then_set: begin
          if (ins[cxe_pkg::SEL_ZF]) begin
            nxt_s.fl.z = ~a[bsel];
          end else begin
            nxt_s.fl.c = a[bsel];
          end
          if (op == cxe_pkg::op_bit_test_then_set) begin
            nxt_s.opa = a | (16'h0001 << bsel);
          end
        end
        cxe_pkg::op_compare_to_zero:
          nxt_s.fl = sub_fl(a, cxe_pkg::ZERO16, 1'b1, 1'b1);
        cxe_pkg::op_compare_with_borrow:
          nxt_s.fl = sub_fl(a, bb, s_ff.fl.c, s_ff.fl.z);
        cxe_pkg::op_compare_skip_equal:   skp = (a == b);
        cxe_pkg::op_compare_skip_greater: skp = $signed(a) > $signed(b);
        cxe_pkg::op_compare_skip_less:    skp = $signed(a) < $signed(b);
        cxe_pkg::op_compare_skip_unequal: skp = (a != b);
        cxe_pkg::op_return_with_literal: begin
          nxt_s.res_lo = {6'h00, ins[9:0]};
          if (s_ff.sp != 4'h0) begin
            nxt_s.res_hi = s_ff.stk[3'(s_ff.sp - 4'h1)];
            nxt_s.sp     = s_ff.sp - 4'h1;
          end
          cyc = ins[cxe_pkg::ALT_BIT] ? cxe_pkg::CYC_TWO
                                      : cxe_pkg::CYC_THREE;
        end
        // packed bcd fix of low byte
        cxe_pkg::op_decimal_adjust_byte: begin
          t = {1'b0, a[7:0]};
          if (t[3:0] > cxe_pkg::DAW_LIM || s_ff.fl.dc) begin
            t = t + cxe_pkg::DAW_LO;
          end
          if (t[7:4] > cxe_pkg::DAW_LIM || s_ff.fl.c || t[8]) begin
            t = t + cxe_pkg::DAW_HI;
          end
          nxt_s.res_lo = {a[15:8], t[7:0]};
          nxt_s.fl.c   = t[8];
        end
        cxe_pkg::op_interrupt_hold_off: nxt_s.hold = ins[13:0];
        cxe_pkg::op_divide: begin
          dvd = ins[1] ? {s_ff.opx, a}
                       : (ins[0] ? {{16{a[15]}}, a} : {16'h0000, a});
          dvs = ins[0] ? {{16{b[15]}}, b} : {16'h0000, b};
          if (b != 16'h0000) begin
            q32 = ins[0] ? 32'($signed(dvd) / $signed(dvs)) : dvd / dvs;
            r32 = ins[0] ? 32'($signed(dvd) % $signed(dvs)) : dvd % dvs;
          end
          nxt_s.res_lo = q32[15:0];
          nxt_s.res_hi = r32[15:0];
          nxt_s.fl.n   = q32[15];
          nxt_s.fl.z   = (q32[15:0] == 16'h0000);
          nxt_s.fl.c   = (r32[15:0] != 16'h0000);
          nxt_s.fl.ov  = (b == 16'h0000) || (ins[0]
                         ? (q32[31:15] != {17{q32[15]}})
                         : (q32[31:16] != 16'h0000));
          cyc = cxe_pkg::CYC_DIV;
        end
        cxe_pkg::op_find_first_one_msb, cxe_pkg::op_find_first_one_lsb:
        begin
          nxt_s.res_lo = {11'h000,
                          ff1(a, op == cxe_pkg::op_find_first_one_msb)};
          nxt_s.fl.c   = (a == 16'h0000);
        end
        cxe_pkg::op_move_double: begin
          nxt_s.res_lo = a;
          nxt_s.res_hi = s_ff.opx;
          cyc          = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_product_op: begin
          pw = $signed({ins[1] & a[15], a}) * $signed({ins[0] & bb[15], bb});
          nxt_s.res_lo = pw[15:0];
          nxt_s.res_hi = pw[31:16];
        end
        // stack forms; full stack drops a push
        cxe_pkg::op_push: begin
          if (s_ff.sp != cxe_pkg::STK_D) begin
            nxt_s.stk[s_ff.sp[2:0]] = a;
            nxt_s.sp = s_ff.sp + 4'h1;
          end
        end
        cxe_pkg::op_push_double: begin
          if (s_ff.sp < cxe_pkg::STK_D - 4'h1) begin
            nxt_s.stk[s_ff.sp[2:0]]          = a;
            nxt_s.stk[3'(s_ff.sp + 4'h1)]    = s_ff.opx;
            nxt_s.sp = s_ff.sp + 4'h2;
          end
          cyc = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_pop: begin
          if (s_ff.sp != 4'h0) begin
            nxt_s.res_lo = s_ff.stk[3'(s_ff.sp - 4'h1)];
            nxt_s.sp     = s_ff.sp - 4'h1;
          end
        end
        cxe_pkg::op_pop_double: begin
          if (s_ff.sp > 4'h1) begin
            nxt_s.res_hi = s_ff.stk[3'(s_ff.sp - 4'h1)];
            nxt_s.res_lo = s_ff.stk[3'(s_ff.sp - 4'h2)];
            nxt_s.sp     = s_ff.sp - 4'h2;
          end
          cyc = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_push_shadow: nxt_s.shadow = s_ff.fl;
        cxe_pkg::op_pop_shadow:  nxt_s.fl     = s_ff.shadow;
        cxe_pkg::op_power_save_entry: begin
          nxt_s.watchdog_timeout_flag = 1'b0;
          if (ins[0]) begin
            nxt_s.idle_md = 1'b1;
          end else begin
            nxt_s.sleep    = 1'b1;
            nxt_s.sleep_md = 1'b1;
          end
        end
        // extra runs of the next instruction
        cxe_pkg::op_repeat:
          nxt_s.rep = ins[cxe_pkg::SEL_REG] ? b : {2'h0, ins[13:0]};
        cxe_pkg::op_rotate_left_via_carry: begin
          nxt_s.res_lo = {a[14:0], s_ff.fl.c};
          nxt_s.fl.c   = a[15];
        end
        cxe_pkg::op_rotate_right_via_carry: begin
          nxt_s.res_lo = {s_ff.fl.c, a[15:1]};
          nxt_s.fl.c   = a[0];
        end
        cxe_pkg::op_rotate_left:  nxt_s.res_lo = {a[14:0], a[15]};
        cxe_pkg::op_rotate_right: nxt_s.res_lo = {a[0], a[15:1]};
        cxe_pkg::op_sign_extend: begin
          nxt_s.res_lo = {{8{a[7]}}, a[7:0]};
          nxt_s.fl.c   = ~a[7];
        end
        cxe_pkg::op_clear_upper_extend: begin
          nxt_s.res_lo = {8'h00, a[7:0]};
          nxt_s.fl.c   = 1'b1;
        end
        cxe_pkg::op_table_read_high: begin
          nxt_s.res_lo = {8'h00, s_ff.mem[ix][23:16]};
          cyc          = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_table_read_low: begin
          nxt_s.res_lo = s_ff.mem[ix][15:0];
          cyc          = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_table_write_high: begin
          nxt_s.mem[ix][23:16] = b[7:0];
          cyc                  = cxe_pkg::CYC_TWO;
        end
        cxe_pkg::op_table_write_low: begin
          nxt_s.mem[ix][15:0] = b;
          cyc                 = cxe_pkg::CYC_TWO;
        end
        // single shift touches carry and overflow
        cxe_pkg::op_shift_one: begin
          nxt_s.res_lo = {a[14:0], 1'b0};
          nxt_s.fl.c   = a[15];
          nxt_s.fl.ov  = a[15] ^ a[14];
        end
        cxe_pkg::op_shift_multi: nxt_s.res_lo = a << bb[4:0];
        cxe_pkg::op_move_indirect: begin
          nxt_s.res_hi = ea;
          if (ins[cxe_pkg::ALT_BIT]) begin
            nxt_s.mem[ea[2:0]][15:0] = b;
          end else begin
            nxt_s.res_lo = s_ff.mem[ea[2:0]][15:0];
          end
        end
        cxe_pkg::op_move_byte_literal: nxt_s.res_lo = {a[15:8], ins[7:0]};
        cxe_pkg::op_move_word_literal: nxt_s.res_lo = ins[15:0];
        cxe_pkg::op_negate: begin
          nxt_s.res_lo = sub_r(cxe_pkg::ZERO16, a, 1'b1);
          nxt_s.fl     = sub_fl(cxe_pkg::ZERO16, a, 1'b1, 1'b1);
        end
        // zero opcode and unknown codes do nothing
        default: begin
        end
      endcase
      // shared negative and zero update for rotate, extend and shift results
      unique case (op)
        cxe_pkg::op_rotate_left_via_carry, cxe_pkg::op_rotate_right_via_carry,
        cxe_pkg::op_rotate_left, cxe_pkg::op_rotate_right,
        cxe_pkg::op_sign_extend, cxe_pkg::op_clear_upper_extend,
        cxe_pkg::op_shift_one, cxe_pkg::op_shift_multi: begin
          nxt_s.fl.n = nxt_s.res_lo[15];
          nxt_s.fl.z = (nxt_s.res_lo == 16'h0000);
        end
        default: begin
        end
      endcase
      // skipped length picks two or three
      if (skp) begin
        cyc = s_ff.cnt == 5'h00 && wb_req.dat[cxe_pkg::DBL_BIT]
              || s_ff.cnt != 5'h00 && s_ff.dbl
              ? cxe_pkg::CYC_THREE : cxe_pkg::CYC_TWO;
      end
      nxt_s.skip     = skp;
      nxt_s.cnt      = cyc;
      nxt_s.cyc_last = cyc;
    end else if (s_ff.cnt != 5'h00) begin
      nxt_s.cnt = s_ff.cnt - 5'h01;
    end
    nxt_s.hold_on = (nxt_s.hold != 14'h0000);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_ack_o     = s_ff.ack;
  assign wb_dat_o     = s_ff.rdat;
  assign int_hold_off = s_ff.hold_on;
  assign sleep_mode   = s_ff.sleep_md;
  assign idle_mode    = s_ff.idle_md;

endmodule
`default_nettype wire

// ### verification/cxe_exec_unit_asserts.sv
// Purpose: port checks on the execution unit
// Assumes: one clock, synchronous reset
// Notes:   request held until acked
`timescale 1ns/1ps
`default_nettype none
module cxe_exec_asserts (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 reset,
  // bus
  input wire cxe_pkg::cxe_wb_req_t wb_req,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // core state
  input wire logic                 int_hold_off,
  input wire logic                 sleep_mode,
  input wire logic                 idle_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic req;
  logic rd;
  assign req = wb_req.cyc & wb_req.stb;
  assign rd = wb_ack_o & ~wb_req.we;
  sequence s_new; req && !$past(req); endsequence
  sequence s_one; wb_ack_o ##1 !wb_ack_o; endsequence
  req_ack_a: assert property (s_new |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |-> s_one)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  reset_quiet_a: assert property ($fell(reset) |->
    !(wb_ack_o | int_hold_off | sleep_mode | idle_mode))
    else $error("outputs not quiet after reset");
  sleep_cause_a: assert property (
    $rose(sleep_mode) |-> $past(wb_ack_o && wb_req.we))
    else $error("sleep without write");
  idle_cause_a: assert property (
    $rose(idle_mode) |-> $past(wb_ack_o && wb_req.we))
    else $error("idle without write");
  hold_cause_a: assert property (
    $rose(int_hold_off) |-> $past(wb_ack_o && wb_req.we))
    else $error("hold-off without launch");
  unmapped_zero_a: assert property (rd && (wb_req.adr > 8'h1C
    || wb_req.adr[1:0] != 2'h0) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  mode_mirror_a: assert property (rd && wb_req.adr == 8'h10
    |-> wb_dat_o[8:7] == {idle_mode, sleep_mode})
    else $error("status modes differ");
endmodule
`default_nettype wire

// ### verification/test_cxe_exec_unit.sv
// Purpose: scenario bench for the execution unit
// Assumes: classic wishbone master, ack sampled at rising edge
// Notes:   ack and read data taken at the rising edge, pre-update values
`timescale 1ns/1ps
`default_nettype none
module test_cxe_exec_unit;
  logic                 mclk = 1'h0;
  logic                 reset = 1'h1;
  cxe_pkg::cxe_wb_req_t wb_req = '0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 int_hold_off;
  logic                 sleep_mode;
  logic                 idle_mode;
  logic [31:0]          q;
  int                   num_errors = 0;
  int                   n_compared = 0;
  always #25 mclk = ~mclk;
  cxe_exec_unit dut_u (.mclk(mclk), .reset(reset), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .int_hold_off(int_hold_off), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_req <= '0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic run(input cxe_pkg::cxe_op_t op, input logic [15:0] f,
      input logic [15:0] a, input logic [15:0] b, input logic dbl);
    xfer(1'h1, cxe_pkg::REG_OPA, {16'h0000, a});
    xfer(1'h1, cxe_pkg::REG_OPB, {16'h0000, b});
    xfer(1'h1, cxe_pkg::REG_CMD, {7'h00, dbl, op, f});
    q = 32'hFFFF_FFFF;
    // busy until the launched count has run down
    while (q[9] !== 1'h0) begin
      xfer(1'h0, cxe_pkg::REG_STAT, 32'h0000_0000);
    end
    xfer(1'h0, cxe_pkg::REG_INFO, 32'h0000_0000);
  endtask
  task automatic t_skip();
    cxe_pkg::cxe_op_t ops[4];
    logic [4:0] cy[4];
    ops = '{cxe_pkg::op_compare_skip_equal, cxe_pkg::op_compare_skip_greater,
      cxe_pkg::op_compare_skip_less, cxe_pkg::op_compare_skip_unequal};
    cy = '{5'h01, 5'h02, 5'h01, 5'h02};
    run(cxe_pkg::op_bit_test_skip_set, 16'h0004, 16'h0010, 16'h0000, 1'h0);
    chk(q[4:0], cxe_pkg::CYC_TWO);
    run(cxe_pkg::op_bit_test_skip_set, 16'h0004, 16'h0010, 16'h0000, 1'h1);
    chk(q[4:0], cxe_pkg::CYC_THREE);
    run(cxe_pkg::op_bit_test_skip_set, 16'h0005, 16'h0010, 16'h0000, 1'h0);
    chk(q[4:0], cxe_pkg::CYC_ONE);
    for (int i = 0; i < 4; i++) begin
      run(ops[i], 16'h0000, 16'h0005, 16'h0003, 1'h0);
      chk(q[4:0], cy[i]);
    end
  endtask
  task automatic t_arith();
    run(cxe_pkg::op_compare_to_zero, 16'h0000, 16'h0000, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_STAT, 32'h0000_0013);
    run(cxe_pkg::op_negate, 16'h0000, 16'h0001, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_FFFF);
    // carry now clear, so the borrow must be taken
    run(cxe_pkg::op_compare_with_borrow, 16'h0000, 16'h0005, 16'h0005, 1'h0);
    rchk(cxe_pkg::REG_STAT, 32'h0000_0008);
    run(cxe_pkg::op_divide, 16'h0000, 16'h0064, 16'h0007, 1'h0);
    chk(q[4:0], cxe_pkg::CYC_DIV);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_000E);
    rchk(cxe_pkg::REG_RESHI, 32'h0000_0002);
    run(cxe_pkg::op_product_op, 16'h0000, 16'h1234, 16'h0100, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_3400);
    rchk(cxe_pkg::REG_RESHI, 32'h0000_0012);
    run(cxe_pkg::op_sign_extend, 16'h0000, 16'h0080, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_FF80);
    run(cxe_pkg::op_clear_upper_extend, 16'h0000, 16'h1280, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_0080);
  endtask
  task automatic t_table();
    run(cxe_pkg::op_table_write_low, 16'h0000, 16'h0003, 16'hBEEF, 1'h0);
    chk(q[4:0], cxe_pkg::CYC_TWO);
    run(cxe_pkg::op_table_write_high, 16'h0000, 16'h0003, 16'h12AB, 1'h0);
    run(cxe_pkg::op_table_read_low, 16'h0000, 16'h0003, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_BEEF);
    run(cxe_pkg::op_table_read_high, 16'h0000, 16'h0003, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_00AB);
  endtask
  task automatic t_modes();
    run(cxe_pkg::op_power_save_entry, 16'h0000, 16'h0000, 16'h0000, 1'h0);
    chk({sleep_mode, idle_mode}, 2'h2);
    xfer(1'h1, cxe_pkg::REG_STAT, 32'h0000_0000);
    run(cxe_pkg::op_power_save_entry, 16'h0001, 16'h0000, 16'h0000, 1'h0);
    chk({sleep_mode, idle_mode}, 2'h1);
    xfer(1'h1, cxe_pkg::REG_STAT, 32'h0000_0000);
    xfer(1'h1, cxe_pkg::REG_CMD, {8'h00, cxe_pkg::op_interrupt_hold_off,
      16'h0010});
    @(negedge mclk);
    chk(int_hold_off, 1'h1);
    repeat (40) @(negedge mclk);
    chk(int_hold_off, 1'h0);
    xfer(1'h1, 8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, 32'h0000_0000);
    rchk(8'h05, 32'h0000_0000);
  endtask
  task automatic t_more();
    xfer(1'h1, cxe_pkg::REG_STAT, 32'h0000_0000);
    run(cxe_pkg::op_decimal_adjust_byte, 16'h0000, 16'h551A, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_5520);
    run(cxe_pkg::op_find_first_one_lsb, 16'h0000, 16'h0050, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_0005);
    run(cxe_pkg::op_find_first_one_msb, 16'h0000, 16'h0050, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_000A);
    run(cxe_pkg::op_bit_test_to_flag, 16'h0013, 16'h0000, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_STAT, 32'h0000_0002);
    run(cxe_pkg::op_rotate_left_via_carry, 16'h0000, 16'h8001, 16'h0000,
      1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_0002);
    rchk(cxe_pkg::REG_STAT, 32'h0000_0001);
    run(cxe_pkg::op_shift_multi, 16'h8003, 16'h0011, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_0088);
    run(cxe_pkg::op_move_word_literal, 16'hBEEF, 16'h0000, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_BEEF);
    run(cxe_pkg::op_move_byte_literal, 16'h00A5, 16'h1200, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_12A5);
    run(cxe_pkg::op_move_double, 16'h0000, 16'h1357, 16'h0000, 1'h0);
    chk(q[4:0], cxe_pkg::CYC_TWO);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_1357);
    run(cxe_pkg::op_move_indirect, 16'h0402, 16'h0001, 16'h4321, 1'h0);
    run(cxe_pkg::op_move_indirect, 16'h03FF, 16'h0004, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_4321);
    rchk(cxe_pkg::REG_RESHI, 32'h0000_0003);
    // one push, then three by repeat: pops tell the run count
    run(cxe_pkg::op_push, 16'h0000, 16'h2222, 16'h0000, 1'h0);
    run(cxe_pkg::op_repeat, 16'h0002, 16'h0000, 16'h0000, 1'h0);
    run(cxe_pkg::op_push, 16'h0000, 16'h1111, 16'h0000, 1'h0);
    run(cxe_pkg::op_pop_double, 16'h0000, 16'h0000, 16'h0000, 1'h0);
    run(cxe_pkg::op_pop, 16'h0000, 16'h0000, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_1111);
    run(cxe_pkg::op_pop, 16'h0000, 16'h0000, 16'h0000, 1'h0);
    rchk(cxe_pkg::REG_RESLO, 32'h0000_2222);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    t_skip();
    t_arith();
    t_table();
    t_modes();
    t_more();
    finish_test();
  end
  // generous bound over the whole sequence
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule
bind cxe_exec_unit cxe_exec_asserts chk_u (.mclk(mclk), .reset(reset),
  .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .int_hold_off(int_hold_off), .sleep_mode(sleep_mode),
  .idle_mode(idle_mode));
`default_nettype wire
